// file: logic/ssl_pkg.sv
`default_nettype none
// ============================================================================
// Shared constants for the serial setup word loader.
// ============================================================================
package ssl_pkg;

  // ==========================================================================
  // Setup word layout.
  // ==========================================================================
  localparam int unsigned SETUP_BITS    = 16;           // Bits in one setup update.
  localparam int unsigned BIT_CLKDIV    = 13;           // Clock divider select.
  localparam int unsigned BIT_RANGE_HI  = 10;           // Full-scale range, upper bit.
  localparam int unsigned BIT_RANGE_LO  = 9;            // Full-scale range, lower bit.
  localparam int unsigned BIT_WIDE      = 8;            // Output word width select.
  localparam int unsigned BIT_GRADE     = 7;            // Speed grade match.
  localparam int unsigned BIT_TEST      = 0;            // Zero-input test.
  localparam logic [15:0] SETUP_RESET   = 16'h0000;     // Setup word after reset.

  // ==========================================================================
  // Readback stream layout, in bits.
  // ==========================================================================
  localparam logic [10:0] ZEROS_WIDE    = 11'h140;      // Leading zeros, 20-bit words (320).
  localparam logic [10:0] ZEROS_NARROW  = 11'h100;      // Leading zeros, 16-bit words (256).
  localparam logic [10:0] REV_BITS      = 11'h004;      // Revision field length.
  localparam logic [10:0] CHECK_WIDE    = 11'h12c;      // Check pattern length, 20-bit (300).
  localparam logic [10:0] CHECK_NARROW  = 11'h0ec;      // Check pattern length, 16-bit (236).
  localparam logic [10:0] PAT_WIDE      = 11'h048;      // Nonzero tail, 20-bit (72).
  localparam logic [10:0] PAT_NARROW    = 11'h038;      // Nonzero tail, 16-bit (56).
  localparam logic [10:0] TOTAL_WIDE    = 11'h500;      // Whole readback, 20-bit (1280).
  localparam logic [10:0] TOTAL_NARROW  = 11'h400;      // Whole readback, 16-bit (1024).
  localparam logic [71:0] PATTERN_WIDE  = 72'h30f066012480f69055;
  localparam logic [71:0] PATTERN_NARROW = 72'h0000_30f066012480f6;

  // Revision field; the value is arbitrary.
  localparam logic [3:0]  REVISION_ID   = 4'h1;

  // ==========================================================================
  // Counters.
  // ==========================================================================
  localparam logic [3:0]  LAST_SETUP_BIT = 4'hf;        // Index of the sixteenth bit.
  localparam logic [1:0]  DIV4_LAST      = 2'h3;        // Last phase of divide by four.

  // Load, readback and run phases.
  typedef enum logic [1:0] {
    SSL_LOAD = 2'b00,   // Taking setup bits after reset.
    SSL_READ = 2'b01,   // Setup word held, readback allowed.
    SSL_RUN  = 2'b10    // Normal operation started.
  } ssl_phase_type;

endpackage
`default_nettype wire

// file: logic/ssl_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// ============================================================================
module ssl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta_ff;

  // Both stages clear to a constant so no pin value leaks through reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// file: logic/ssl_loader.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Serial setup word loader: write path, field decode and readback stream.
// ============================================================================
module ssl_loader
  import ssl_pkg::*;
(
  // System clock and device reset.
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  // Setup write pins.
  input  wire logic       SETUP_CLK,
  input  wire logic       SETUP_DATA,
  // Readback pins.
  input  wire logic       READOUT_CLK,
  input  wire logic       CHAIN_DATA_IN,
  output var  logic       DATA_OUT,
  // Integrate toggle pin.
  input  wire logic       INTEGRATE_TOGGLE,
  // Setup word and its decoded fields.
  output var  logic [15:0] SETUP_WORD,
  output var  logic       SETUP_LOADED,
  output var  logic       RUN_STARTED,
  output var  logic       CLK_DIV4_SEL,
  output var  logic [1:0] FULL_SCALE_RANGE,
  output var  logic       WIDE_WORD,
  output var  logic       SPEED_GRADE_HIGH,
  output var  logic       ZERO_INPUT_TEST,
  output var  logic       INTERNAL_CLK_TICK
);

  // ==========================================================================
  // Readback stream bit lookup.
  // ==========================================================================
  // Returns the bit at position idx of one readback sequence.
  function automatic logic stream_bit(input logic [10:0] idx, input logic wide, input logic [15:0] word);
    logic [10:0] zeros;
    logic [10:0] check_len;
    logic [10:0] pat_len;
    logic [10:0] j;
    logic [71:0] pat;
    logic [10:0] k;
    stream_bit = 1'b0;
    zeros      = wide ? ZEROS_WIDE : ZEROS_NARROW;
    check_len  = wide ? CHECK_WIDE : CHECK_NARROW;
    pat_len    = wide ? PAT_WIDE : PAT_NARROW;
    pat        = wide ? PATTERN_WIDE : PATTERN_NARROW;
    j          = 11'h000;
    k          = 11'h000;
    if (idx < zeros) begin
      // Leading run of zeros.
      stream_bit = 1'b0;
    end else if (idx < zeros + 11'(SETUP_BITS)) begin
      // Setup word, most significant bit first.
      j          = idx - zeros;
      stream_bit = word[4'(LAST_SETUP_BIT - j[3:0])];
    end else if (idx < zeros + 11'(SETUP_BITS) + REV_BITS) begin
      // Revision field, most significant bit first.
      j          = idx - zeros - 11'(SETUP_BITS);
      stream_bit = REVISION_ID[2'(2'h3 - j[1:0])];
    end else begin
      // Check pattern: zeros, then the nonzero tail.
      j = idx - zeros - 11'(SETUP_BITS) - REV_BITS;
      if (j >= check_len - pat_len) begin
        k          = pat_len - 11'h001 - (j - (check_len - pat_len));
        stream_bit = pat[7'(k)];
      end
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  // Every pin from the host is a foreign clock domain, so it crosses twice.
  logic [4:0] pins_sync;                      // Synchronised pin levels.

  ssl_sync #(
    .WIDTH    (5)
  ) u_sync (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .async_in ({SETUP_CLK, SETUP_DATA, READOUT_CLK, CHAIN_DATA_IN, INTEGRATE_TOGGLE}),
    .sync_out (pins_sync)
  );

  // ==========================================================================
  // State record.
  // ==========================================================================
  typedef struct packed {
    ssl_phase_type phase;        // Load, readback or run.
    logic          scl_last;     // Previous setup clock level.
    logic          rck_last;     // Previous readout clock level.
    logic          tog_last;     // Integrate toggle level seen on entering readback.
    logic [15:0]   shift;        // Incoming setup bits.
    logic [3:0]    bit_cnt;      // Setup bits taken so far.
    logic [15:0]   word;         // Committed setup word.
    logic [10:0]   rb_cnt;       // Readback bit position.
    logic          passing;      // Own stream done; chain input forwarded.
    logic          dout;         // Data output.
    logic [1:0]    div_cnt;      // Internal clock divider phase.
    logic          tick;         // Internal clock enable pulse.
    logic          loaded;       // Setup word committed; drives its own output flop.
    logic          running;      // Normal operation started; drives its own output flop.
  } ssl_state_type;

  ssl_state_type cur_ff;         // Registered state.
  ssl_state_type nxt_st;         // Next state.

  logic scl_s;                   // Synchronised setup clock.
  logic sda_s;                   // Synchronised setup data.
  logic rck_s;                   // Synchronised readout clock.
  logic chain_s;                 // Synchronised chain input.
  logic tog_s;                   // Synchronised integrate toggle.

  assign {scl_s, sda_s, rck_s, chain_s, tog_s} = pins_sync;

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  // Edges are found on the synchronised levels; the two-cycle latency is far
  // below the host's minimum clock periods, so no edge is merged or missed.
  always_comb begin
    logic [10:0] total;
    logic        wide;
    total    = TOTAL_NARROW;
    wide     = cur_ff.word[BIT_WIDE];
    nxt_st   = cur_ff;
    nxt_st.scl_last = scl_s;
    nxt_st.rck_last = rck_s;
    total    = wide ? TOTAL_WIDE : TOTAL_NARROW;

    // Internal clock enable: every cycle, or every fourth with the divider.
    if (cur_ff.word[BIT_CLKDIV]) begin
      nxt_st.div_cnt = cur_ff.div_cnt + 2'h1;
      nxt_st.tick    = (cur_ff.div_cnt == DIV4_LAST);
    end else begin
      nxt_st.div_cnt = 2'h0;
      nxt_st.tick    = 1'b1;
    end

    unique case (cur_ff.phase)
      SSL_LOAD: begin
        // Take one bit per falling setup clock edge, first bit lands on top.
        nxt_st.dout = 1'b0;
        if (cur_ff.scl_last && !scl_s) begin
          nxt_st.shift   = {cur_ff.shift[14:0], sda_s};
          nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
          // Only the sixteenth bit commits the word; a short write never does.
          if (cur_ff.bit_cnt == LAST_SETUP_BIT) begin
            nxt_st.word     = {cur_ff.shift[14:0], sda_s};
            nxt_st.phase    = SSL_READ;
            nxt_st.loaded   = 1'b1;
            nxt_st.rb_cnt   = 11'h000;
            nxt_st.passing  = 1'b0;
            nxt_st.tog_last = tog_s;
          end
        end
      end
      SSL_READ: begin
        // Each rising readout clock edge presents the next stream bit.
        if (!cur_ff.rck_last && rck_s) begin
          if (cur_ff.passing) begin
            nxt_st.dout = chain_s;
          end else begin
            // The sequence repeats, so the position folds at half the total.
            nxt_st.dout = stream_bit(cur_ff.rb_cnt >= (total >> 1) ? cur_ff.rb_cnt - (total >> 1)
                                     : cur_ff.rb_cnt, wide, cur_ff.word);
            if (cur_ff.rb_cnt == total - 11'h001) begin
              nxt_st.passing = 1'b1;
            end else begin
              nxt_st.rb_cnt = cur_ff.rb_cnt + 11'h001;
            end
          end
        end
        // A toggle change ends readback and starts normal operation.
        if (tog_s != cur_ff.tog_last) begin
          nxt_st.phase = SSL_RUN;
          nxt_st.running = 1'b1;
          nxt_st.dout  = 1'b0;
        end
      end
      SSL_RUN: begin
        // Conversion data leave through another path; hold the line low.
        nxt_st.dout = 1'b0;
      end
      default: begin
        // An illegal phase code falls back to loading, with both flags cleared.
        nxt_st.phase   = SSL_LOAD;
        nxt_st.loaded  = 1'b0;
        nxt_st.running = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  // The reset acts at once and loads constants only, so a held reset also
  // clears any half-shifted setup word.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_ff <= '{phase: SSL_LOAD, scl_last: 1'b0, rck_last: 1'b0, tog_last: 1'b0,
                  shift: SETUP_RESET, bit_cnt: 4'h0, word: SETUP_RESET, rb_cnt: 11'h000,
                  passing: 1'b0, dout: 1'b0, div_cnt: 2'h0, tick: 1'b0,
                  loaded: 1'b0, running: 1'b0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register.
  // ==========================================================================
  assign DATA_OUT          = cur_ff.dout;
  assign SETUP_WORD        = cur_ff.word;
  assign SETUP_LOADED      = cur_ff.loaded;
  assign RUN_STARTED       = cur_ff.running;
  assign CLK_DIV4_SEL      = cur_ff.word[BIT_CLKDIV];
  assign FULL_SCALE_RANGE  = cur_ff.word[BIT_RANGE_HI:BIT_RANGE_LO];
  assign WIDE_WORD         = cur_ff.word[BIT_WIDE];
  assign SPEED_GRADE_HIGH  = cur_ff.word[BIT_GRADE];
  assign ZERO_INPUT_TEST   = cur_ff.word[BIT_TEST];
  assign INTERNAL_CLK_TICK = cur_ff.tick;

endmodule
`default_nettype wire

// file: testbench/ssl_loader_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Port checker for the setup word loader.
// ============================================================================
module ssl_monitor
  import ssl_pkg::*;
(
  // Clock, reset and host pins.
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        SETUP_CLK,
  input wire logic        SETUP_DATA,
  input wire logic        READOUT_CLK,
  input wire logic        CHAIN_DATA_IN,
  input wire logic        DATA_OUT,
  input wire logic        INTEGRATE_TOGGLE,
  // Setup word and decodes.
  input wire logic [15:0] SETUP_WORD,
  input wire logic        SETUP_LOADED,
  input wire logic        RUN_STARTED,
  input wire logic        CLK_DIV4_SEL,
  input wire logic [1:0]  FULL_SCALE_RANGE,
  input wire logic        WIDE_WORD,
  input wire logic        SPEED_GRADE_HIGH,
  input wire logic        ZERO_INPUT_TEST,
  input wire logic        INTERNAL_CLK_TICK
);
  // One clock domain, so the clock and reset are given once.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_clkdiv_decode: assert property (CLK_DIV4_SEL == SETUP_WORD[13])
    else $error("divider select differs from setup word");
  a_range_decode: assert property (FULL_SCALE_RANGE == SETUP_WORD[10:9])
    else $error("range field differs from setup word");
  a_width_decode: assert property (WIDE_WORD == SETUP_WORD[8])
    else $error("width select differs from setup word");
  a_test_decode: assert property (ZERO_INPUT_TEST == SETUP_WORD[0])
    else $error("zero test differs from setup word");
  // A divided tick must come back exactly every fourth cycle.
  a_tick_div_four: assert property (CLK_DIV4_SEL && INTERNAL_CLK_TICK |=> !INTERNAL_CLK_TICK [*3] ##1 INTERNAL_CLK_TICK)
    else $error("divided tick period wrong");
  // The tick is still low at the release edge, so the check waits for a sampled high reset.
  a_tick_every_cycle: assert property (RST_N && !CLK_DIV4_SEL |=> INTERNAL_CLK_TICK || CLK_DIV4_SEL)
    else $error("undivided tick missing");
  // Once committed, late setup bits must not disturb the word.
  a_word_frozen: assert property (SETUP_LOADED |=> $stable(SETUP_WORD) && SETUP_LOADED)
    else $error("setup word changed after commit");
  a_output_quiet: assert property (!SETUP_LOADED || RUN_STARTED |-> !DATA_OUT)
    else $error("readback line active outside readback");
  a_toggle_starts: assert property (SETUP_LOADED && !RUN_STARTED && $changed(INTEGRATE_TOGGLE) |-> ##[1:6] RUN_STARTED)
    else $error("toggle did not start normal operation");
endmodule

bind ssl_loader ssl_monitor ssl_monitor_i (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SETUP_CLK(SETUP_CLK), .SETUP_DATA(SETUP_DATA),
  .READOUT_CLK(READOUT_CLK), .CHAIN_DATA_IN(CHAIN_DATA_IN), .DATA_OUT(DATA_OUT),
  .INTEGRATE_TOGGLE(INTEGRATE_TOGGLE), .SETUP_WORD(SETUP_WORD), .SETUP_LOADED(SETUP_LOADED),
  .RUN_STARTED(RUN_STARTED), .CLK_DIV4_SEL(CLK_DIV4_SEL), .FULL_SCALE_RANGE(FULL_SCALE_RANGE),
  .WIDE_WORD(WIDE_WORD), .SPEED_GRADE_HIGH(SPEED_GRADE_HIGH), .ZERO_INPUT_TEST(ZERO_INPUT_TEST),
  .INTERNAL_CLK_TICK(INTERNAL_CLK_TICK));
`default_nettype wire

// file: testbench/ssl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Host controller model: drives the setup and readout pins.
// ============================================================================
module ssl_host_model (
  // Bench clock.
  input  wire logic sys_clk,
  // Pins toward the device.
  output var  logic setup_clk,
  output var  logic setup_data,
  output var  logic readout_clk,
  output var  logic chain_data_in,
  output var  logic integrate_toggle,
  // Readback line.
  input  wire logic data_out
);
  // Toggle starts low so a write may begin after reset.
  initial begin
    setup_clk = 1'b0;
    setup_data = 1'b0;
    readout_clk = 1'b0;
    chain_data_in = 1'b0;
    integrate_toggle = 1'b0;
  end

  // Wait of 2 us, 100 cycles, before setup or readout clocking.
  task automatic gap_2us();
    repeat (100) @(posedge sys_clk);
  endtask

  // Shift the top count bits of word, first bit 15; data is stable around each fall.
  task automatic write_bits(input logic [15:0] word, input int count);
    for (int i = 15; i > 15 - count; i--) begin
      @(posedge sys_clk) setup_clk <= 1'b1;
      setup_data <= word[i];
      repeat (3) @(posedge sys_clk);
      @(posedge sys_clk) setup_clk <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    // Released data line shows the inverse, not a stale level.
    @(posedge sys_clk) setup_data <= ~setup_data;
  endtask

  // One readout clock; chain level for the following bit is set in the low phase.
  task automatic read_bit(input logic chain_nxt, output logic b);
    @(posedge sys_clk) readout_clk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) b = data_out;
    @(posedge sys_clk) readout_clk <= 1'b0;
    chain_data_in <= chain_nxt;
    repeat (3) @(posedge sys_clk);
  endtask

  // The toggle stays put during readback and changes only on request.
  task automatic flip_toggle();
    @(posedge sys_clk) integrate_toggle <= ~integrate_toggle;
  endtask
endmodule
`default_nettype wire

// file: testbench/test_serial_setup_word_loader.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Self-checking bench for the setup word loader.
// ============================================================================
module test_serial_setup_word_loader;
  import ssl_pkg::*;
  logic sys_clk, rst_n, s_clk, s_dat, r_clk, chain, tog, d_out, loaded, run, div4, wide, grade, ztest, tick;
  logic [15:0] word;
  logic [1:0]  range_sel;
  int          num_errors = 0;
  int          tests_run = 0;

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  ssl_loader ssl_loader_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .SETUP_CLK(s_clk), .SETUP_DATA(s_dat),
    .READOUT_CLK(r_clk), .CHAIN_DATA_IN(chain), .DATA_OUT(d_out), .INTEGRATE_TOGGLE(tog), .SETUP_WORD(word),
    .SETUP_LOADED(loaded), .RUN_STARTED(run), .CLK_DIV4_SEL(div4), .FULL_SCALE_RANGE(range_sel),
    .WIDE_WORD(wide), .SPEED_GRADE_HIGH(grade), .ZERO_INPUT_TEST(ztest), .INTERNAL_CLK_TICK(tick));
  ssl_host_model ssl_host_model_i (.sys_clk(sys_clk), .setup_clk(s_clk), .setup_data(s_dat),
    .readout_clk(r_clk), .chain_data_in(chain), .integrate_toggle(tog), .data_out(d_out));

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Expected readback bit idx of one sequence: zeros, word, revision, check pattern.
  function automatic logic exp_bit(input logic w, input logic [15:0] sw, input int idx);
    int z, c;
    z = w ? int'(ZEROS_WIDE) : int'(ZEROS_NARROW);
    if (idx < z) return 1'b0;
    if (idx < z + 16) return sw[15 - (idx - z)];
    if (idx < z + 20) return REVISION_ID[3 - (idx - z - 16)];
    c = (w ? int'(CHECK_WIDE) : int'(CHECK_NARROW)) - 1 - (idx - z - 20);
    if (c >= (w ? int'(PAT_WIDE) : int'(PAT_NARROW))) return 1'b0;
    return w ? PATTERN_WIDE[c] : PATTERN_NARROW[c];
  endfunction

  // Reset is applied off the edge so that its immediate effect can be seen.
  task automatic reset_device(input int cycles);
    @(negedge sys_clk) rst_n <= 1'b0;
    #1 check("loaded in reset", 16'h0000, {15'h0000, loaded});
    repeat (cycles) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  // Writes a full word and checks every decoded field.
  task automatic write_and_check(input logic [15:0] sw);
    ssl_host_model_i.gap_2us();
    ssl_host_model_i.write_bits(sw, 16);
    repeat (6) @(posedge sys_clk);
    check("setup word", sw, word);
    check("fields", {11'h000, sw[13], sw[10:9], sw[8], sw[7], 1'b1}, {11'h000, div4, range_sel, wide, grade, loaded});
    check("zero test", {15'h0000, sw[0]}, {15'h0000, ztest});
  endtask

  // Both readback sequences, then four forwarded chain bits.
  task automatic readback(input logic w, input logic [15:0] sw);
    int   total;
    logic b;
    total = w ? int'(TOTAL_WIDE) : int'(TOTAL_NARROW);
    ssl_host_model_i.gap_2us();
    for (int i = 0; i < total; i++) begin
      ssl_host_model_i.read_bit(i == total - 1, b);
      check("readback bit", {15'h0000, exp_bit(w, sw, i % (total / 2))}, {15'h0000, b});
    end
    for (int k = 0; k < 4; k++) begin
      ssl_host_model_i.read_bit(k[0], b);
      check("chain bit", {15'h0000, k == 0 ? 1'b1 : ~k[0]}, {15'h0000, b});
    end
  endtask

  // A short write must never commit.
  task automatic test_partial_write();
    ssl_host_model_i.gap_2us();
    ssl_host_model_i.write_bits(16'h0100, 15);
    repeat (8) @(posedge sys_clk);
    check("loaded after 15 bits", 16'h0000, {15'h0000, loaded});
    reset_device(50);
  endtask

  // Wide write with divider on, readback, then start of run.
  task automatic test_wide();
    int n;
    write_and_check(16'h2781);
    readback(1'b1, 16'h2781);
    // No conversion result is read here, so none of the first four is ever used.
    ssl_host_model_i.flip_toggle();
    n = 0;
    while (run !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        num_errors++;
        tally_and_finish();
      end
    end
    check("run started", 16'h0001, {15'h0000, run});
    // The next write must again begin with the toggle low.
    ssl_host_model_i.flip_toggle();
    reset_device(50);
  endtask

  // Narrow write, readback, then bits after commit are refused.
  task automatic test_narrow();
    write_and_check(16'h0400);
    readback(1'b0, 16'h0400);
    ssl_host_model_i.write_bits(16'h2781, 16);
    repeat (6) @(posedge sys_clk);
    check("word after extra bits", 16'h0400, word);
  endtask

  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    check("word after reset", SETUP_RESET, word);
    test_partial_write();
    test_wide();
    test_narrow();
    tally_and_finish();
  end
endmodule
`default_nettype wire
